// [sss_cfg.svh]
// constants for the supply supervisor, reset generator and watchdog
// Overview of operation
// RULE1: power-fail flag low while sense below trip
// RULE2: power-fail flag only valid with supply valid
// RULE3: watchdog fault low after kick stays constant
// RULE4: fault stays low until next kick edge
// RULE5: floating kick input disables watchdog, fault high
// RULE6: fault output forced high during reset
// RULE7: route fault into manual reset for resets
// RULE8: manual reset low holds reset plus 200ms
// RULE9: undriven manual reset input reads inactive high
// RULE10: reset held while supply low, plus 200ms
// RULE11: active-high reset is complement of active-low
// RULE12: low-line warning low near reset threshold
// RULE13: processor treats low-line warning as interrupt
// RULE14: disabled gate forces chip-enable output high
// RULE15: main supply selected above threshold or battery
// RULE16: battery-on high while battery source selected
// RULE17: cell-good high when battery above level, normally
// RULE18: gate disabled during reset, enabled after release
// RULE19: supply power-down disables gate 28us later
// RULE20: watchdog cleared during reset, counts after release
// RULE21: supply dip during hold restarts hold timer
// RULE22: inputs synchronised, intervals counted in clock cycles (chip_enable_in_n is not synchronised; it passes straight through the gate)
// RULE23: power-on: reset asserted, timer cleared, gate off
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

`define SSS_CLK_MHZ        200
`define SSS_HOLD_MS        200
`define SSS_WDOG_MS        1600
`define SSS_GATE_DELAY_US  28
`define SSS_HOLD_CYCLES    (`SSS_HOLD_MS * `SSS_CLK_MHZ * 1000)
`define SSS_WDOG_CYCLES    (`SSS_WDOG_MS * `SSS_CLK_MHZ * 1000)
`define SSS_GATE_CYCLES    (`SSS_GATE_DELAY_US * `SSS_CLK_MHZ)
`define SSS_CNT_W          32
`define SSS_SYNC_W         8
// bit positions inside the synchroniser vector
`define SSS_B_SUPPLY_OK    0
`define SSS_B_LOW_LINE     1
`define SSS_B_POWER_FAIL   2
`define SSS_B_CELL_GOOD    3
`define SSS_B_SUPPLY_VALID 4
`define SSS_B_ABOVE_CELL   5
`define SSS_B_MANUAL_N     6
`define SSS_B_KICK         7
// reset value of the synchroniser: manual reset idles high, comparators low
`define SSS_SYNC_RST       8'h40

`endif

// [sss_pkg.sv]
// types shared by the supervisor modules
`default_nettype none
package sss_pkg;
	typedef enum logic [2:0] {
		ST_HOLD = 3'h1,
		ST_TIME = 3'h2,
		ST_RUN  = 3'h4
	} sss_rst_state_type;

	typedef logic [31:0] sss_count_type;
endpackage : sss_pkg
`default_nettype wire

// [sss_wdog_if.sv]
// link between the reset core and the watchdog timer
`default_nettype none
interface sss_wdog_if;
	logic kick_level;
	logic floating;
	logic in_reset;
	logic fault_n;

	modport ctrl (output kick_level, output floating, output in_reset, input fault_n);
	modport dog  (input kick_level, input floating, input in_reset, output fault_n);
endinterface : sss_wdog_if
`default_nettype wire

// [sss_watchdog.sv]
// watchdog timer: flags a kick input that stays at one level too long
`include "sss_cfg.svh"
`default_nettype none
module sss_watchdog
	import sss_pkg::*;
#(
	parameter sss_count_type TIMEOUT_CYCLES = `SSS_WDOG_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset_n,
	sss_wdog_if.dog   wd
);
	logic          prev_q;
	sss_count_type count_q;
	logic          fault_n_q;
	logic          kick_edge;

	assign kick_edge  = wd.kick_level != prev_q;
	assign wd.fault_n = fault_n_q;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			prev_q <= 1'h0;
		end else begin
			prev_q <= wd.kick_level;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			count_q   <= '0; // [RULE23]
			fault_n_q <= 1'h1;
		end else if (wd.in_reset) begin
			count_q   <= '0; // [RULE20]
			fault_n_q <= 1'h1; // [RULE6]
		end else if (wd.floating) begin
			count_q   <= '0;
			fault_n_q <= 1'h1; // [RULE5]
		end else if (kick_edge) begin
			count_q   <= '0;
			fault_n_q <= 1'h1; // [RULE4]
		end else if (count_q >= TIMEOUT_CYCLES - 32'h1) begin
			// counter parks here; only an edge, a floating input or reset clears the fault
			fault_n_q <= 1'h0; // [RULE3] [RULE4]
		end else begin
			count_q <= count_q + 32'h1; // [RULE20] [RULE22]
		end
	end
endmodule : sss_watchdog
`default_nettype wire

// [sss_supervisor.sv]
// supply supervisor top: reset timing, flags, supply select, chip-enable gate
`include "sss_cfg.svh"
`default_nettype none
module sss_supervisor
	import sss_pkg::*;
#(
	parameter sss_count_type HOLD_CYCLES = `SSS_HOLD_CYCLES,
	parameter sss_count_type WDOG_CYCLES = `SSS_WDOG_CYCLES,
	parameter sss_count_type GATE_CYCLES = `SSS_GATE_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic supply_ok_cmp,
	input  wire logic low_line_cmp,
	input  wire logic power_fail_sense_in,
	input  wire logic cell_good_cmp,
	input  wire logic supply_valid_cmp,
	input  wire logic supply_above_cell_cmp,
	input  wire logic manual_reset_n,
	input  wire logic watchdog_kick_in,
	input  wire logic watchdog_float_in,
	input  wire logic chip_enable_in_n,
	output var  logic reset_out_n,
	output var  logic reset_out,
	output var  logic power_fail_flag_n,
	output var  logic power_flag_valid,
	output var  logic low_line_n,
	output var  logic watchdog_fault_n,
	output var  logic backup_cell_good,
	output var  logic battery_selected,
	output var  logic chip_enable_out_n,
	output var  logic gate_enabled
);
	// -----------------------------------------------------------------
	// input synchronisers
	// -----------------------------------------------------------------
	logic [`SSS_SYNC_W-1:0] sync1_q;
	logic [`SSS_SYNC_W-1:0] sync2_q;
	logic [`SSS_SYNC_W-1:0] raw_in;
	logic                   float1_q;
	logic                   float2_q;
	// float detect has its own pair so the main vector keeps one reset word

	assign raw_in = {watchdog_kick_in, manual_reset_n, supply_above_cell_cmp,
		supply_valid_cmp, cell_good_cmp, power_fail_sense_in, low_line_cmp,
		supply_ok_cmp};

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			// manual reset starts inactive, as if pulled up
			sync1_q <= `SSS_SYNC_RST; // [RULE9]
			sync2_q <= `SSS_SYNC_RST; // [RULE9]
		end else begin
			sync1_q <= raw_in; // [RULE22]
			sync2_q <= sync1_q; // [RULE22]
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			float1_q <= 1'b0;
			float2_q <= 1'b0;
		end else begin
			float1_q <= watchdog_float_in; // [RULE22]
			float2_q <= float1_q;
		end
	end

	logic supply_ok_s;
	logic manual_n_s;
	logic reset_cause;

	assign supply_ok_s = sync2_q[`SSS_B_SUPPLY_OK];
	assign manual_n_s  = sync2_q[`SSS_B_MANUAL_N];
	assign reset_cause = !supply_ok_s || !manual_n_s; // [RULE8] [RULE10]

	// -----------------------------------------------------------------
	// shared helpers
	// -----------------------------------------------------------------
	// a count has served its time once it sits on its last cycle
	function automatic logic sss_done(input sss_count_type count, input sss_count_type limit);
		return count >= limit - 32'h1;
	endfunction : sss_done

	// -----------------------------------------------------------------
	// reset hold timer
	// -----------------------------------------------------------------
	// two sync flops, one state edge and the output flop: pin to reset pin is four clocks
	sss_rst_state_type state_q;
	sss_count_type     hold_q;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q <= ST_HOLD; // [RULE23]
		end else begin
			case (state_q)
				ST_HOLD: begin
					if (!reset_cause) begin
						state_q <= ST_TIME;
					end
				end
				ST_TIME: begin
					if (reset_cause) begin
						state_q <= ST_HOLD; // [RULE21]
					end else if (sss_done(hold_q, HOLD_CYCLES)) begin
						state_q <= ST_RUN; // [RULE8] [RULE10]
					end
				end
				ST_RUN: begin
					if (reset_cause) begin
						state_q <= ST_HOLD;
					end
				end
				default: begin
					state_q <= ST_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hold_q <= '0;
		end else if (state_q == ST_TIME && !reset_cause) begin
			hold_q <= hold_q + 32'h1; // [RULE22]
		end else begin
			// any dip back into reset starts the 200ms over
			hold_q <= '0; // [RULE21]
		end
	end

	logic in_reset;

	assign in_reset = state_q != ST_RUN;

	// both pins flop on one edge, so they can never be seen apart
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			reset_out_n <= 1'h0; // [RULE23]
			reset_out   <= 1'h1;
		end else begin
			reset_out_n <= !in_reset; // [RULE10] [RULE8]
			reset_out   <= in_reset; // [RULE11]
		end
	end

	// -----------------------------------------------------------------
	// chip-enable gate
	// -----------------------------------------------------------------
	sss_count_type gate_cnt_q;
	logic          gate_q;

	// a supply-only fall keeps the gate open for a short grace time so an
	// access in flight can finish; a manual reset closes it at once
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			gate_q     <= 1'h0; // [RULE23]
			gate_cnt_q <= '0;
		end else if (!in_reset) begin
			gate_q     <= 1'h1; // [RULE18]
			gate_cnt_q <= '0;
		end else if (gate_q && manual_n_s && state_q == ST_HOLD) begin
			if (sss_done(gate_cnt_q, GATE_CYCLES)) begin
				gate_q <= 1'h0; // [RULE19]
			end else begin
				gate_cnt_q <= gate_cnt_q + 32'h1; // [RULE19]
			end
		end else begin
			gate_q     <= 1'h0; // [RULE18]
			gate_cnt_q <= '0;
		end
	end

	assign gate_enabled = gate_q;
	// pass-through is combinational: the gate must not add clock latency
	assign chip_enable_out_n = gate_q ? chip_enable_in_n : 1'h1; // [RULE14]

	// -----------------------------------------------------------------
	// flags and supply selection
	// -----------------------------------------------------------------
	logic main_select;

	// battery takes over only when the supply is both low and below it
	assign main_select = supply_ok_s || sync2_q[`SSS_B_ABOVE_CELL]; // [RULE15]

	// power-fail and low-line flags pass through unmasked; validity has its own pin so the
	// consumer decides what to ignore while the supply is too low
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			power_fail_flag_n <= 1'h0;
			power_flag_valid  <= 1'h0;
			low_line_n        <= 1'h0;
			backup_cell_good  <= 1'h0;
			battery_selected  <= 1'h0;
		end else begin
			power_fail_flag_n <= sync2_q[`SSS_B_POWER_FAIL]; // [RULE1]
			power_flag_valid  <= sync2_q[`SSS_B_SUPPLY_VALID]; // [RULE2] [RULE17]
			low_line_n        <= sync2_q[`SSS_B_LOW_LINE]; // [RULE12]
			backup_cell_good  <= sync2_q[`SSS_B_CELL_GOOD] && main_select; // [RULE17]
			battery_selected  <= !main_select; // [RULE16]
		end
	end

	// -----------------------------------------------------------------
	// watchdog
	// -----------------------------------------------------------------
	// the fault is not looped into manual reset here; the board wires
	// that up when every fault should reset the system
	sss_wdog_if wd_link ();

	assign wd_link.kick_level = sync2_q[`SSS_B_KICK];
	assign wd_link.floating   = float2_q;
	assign wd_link.in_reset   = in_reset; // [RULE6] [RULE20]
	assign watchdog_fault_n   = wd_link.fault_n;

	sss_watchdog #(
		.TIMEOUT_CYCLES (WDOG_CYCLES)
	) u_watchdog (
		.clock   (clock),
		.reset_n (reset_n),
		.wd      (wd_link.dog)
	);
endmodule : sss_supervisor
`default_nettype wire

// [sss_chk.sv]
// port checker for the supply supervisor
`default_nettype none
module sss_chk #(
	parameter int HOLD = 50,
	parameter int WDOG = 200,
	parameter int GATE = 10
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic supply_ok_cmp,
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_in,
	input wire logic watchdog_float_in,
	input wire logic chip_enable_in_n,
	input wire logic reset_out_n,
	input wire logic reset_out,
	input wire logic watchdog_fault_n,
	input wire logic chip_enable_out_n,
	input wire logic gate_enabled
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GMAX = GATE + 4;
	int quiet_q;
	int still_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge clock) begin
		quiet_q <= (!reset_n || !supply_ok_cmp || !manual_reset_n) ? 0 : quiet_q + 1;
	end
	// pin-side age leads the synced copy, hence the slack below
	always_ff @(posedge clock) begin
		still_q <= (!reset_out_n || watchdog_float_in
			|| watchdog_kick_in != $past(watchdog_kick_in)) ? 0 : still_q + 1;
	end
	sequence s_drop; $fell(reset_out_n); endsequence
	sequence s_shut; ##[0:GMAX] !gate_enabled; endsequence
	property p_pair; reset_out == !reset_out_n; endproperty
	property p_ce; chip_enable_out_n == (gate_enabled ? chip_enable_in_n : 1'h1); endproperty
	property p_wdo; !reset_out_n [*2] |-> watchdog_fault_n; endproperty
	property p_cause; (!supply_ok_cmp || !manual_reset_n) |-> ##6 !reset_out_n; endproperty
	property p_hold; $rose(reset_out_n) |-> quiet_q >= HOLD && quiet_q <= HOLD + 8; endproperty
	property p_close; s_drop |-> s_shut; endproperty
	property p_open; $rose(gate_enabled) |-> reset_out_n; endproperty
	property p_dog; $fell(watchdog_fault_n) |-> still_q >= WDOG - 6; endproperty
	a_pair: assert property (p_pair) else $error("reset pair split");
	a_ce: assert property (p_ce) else $error("gated enable wrong");
	a_wdo: assert property (p_wdo) else $error("fault low in reset");
	a_cause: assert property (p_cause) else $error("reset missed");
	a_hold: assert property (p_hold) else $error("hold length");
	a_close: assert property (p_close) else $error("gate stayed open");
	a_open: assert property (p_open) else $error("gate open in reset");
	a_dog: assert property (p_dog) else $error("early fault");
endmodule : sss_chk
`default_nettype wire

// [sss_cpu_model.sv]
// processor model: kicks the watchdog, may loop the fault into manual reset
`default_nettype none
module sss_cpu_model (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic reset_out_n,
	input  wire logic low_line_n,
	input  wire logic fault_n,
	input  wire logic kick_en,
	input  wire logic loop_en,
	output var  logic kick_q,
	output var  logic mr_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_q;
	logic       k_q;
	// kicks only while running, as software would; a low-line warning
	// sends it into its shutdown routine, which stops the kicks
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			div_q <= 3'h0;
			k_q   <= 1'h0;
		end else begin
			div_q <= div_q + 3'h1;
			if (kick_en && reset_out_n && low_line_n && div_q == 3'h7) begin
				k_q <= !k_q;
			end
		end
	end
	assign kick_q = k_q;
	assign mr_n = loop_en ? fault_n : 1'h1;
endmodule : sss_cpu_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the supply supervisor
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 50;
	localparam int WDOG = 200;
	localparam int GATE = 10;
	logic clock = 1'h0, reset_n = 1'h0, supply_ok_cmp = 1'h1, low_line_cmp = 1'h1;
	logic power_fail_sense_in = 1'h1, cell_good_cmp = 1'h1, supply_valid_cmp = 1'h1;
	logic supply_above_cell_cmp = 1'h1, mr_tb_n = 1'h1, watchdog_float_in = 1'h0;
	logic chip_enable_in_n = 1'h0, kick_en = 1'h1, loop_en = 1'h0;
	logic mr_n, watchdog_kick_in, manual_reset_n, reset_out_n, reset_out, gate_enabled;
	logic power_fail_flag_n, power_flag_valid, low_line_n, watchdog_fault_n;
	logic backup_cell_good, battery_selected, chip_enable_out_n;
	int miscompares = 0, n_checks = 0, cyc_n = 0;
	assign manual_reset_n = mr_tb_n & mr_n;
	sss_supervisor #(
		.HOLD_CYCLES (HOLD),
		.WDOG_CYCLES (WDOG),
		.GATE_CYCLES (GATE)
	) sss_supervisor_inst (
		.clock                 (clock),
		.reset_n               (reset_n),
		.supply_ok_cmp         (supply_ok_cmp),
		.low_line_cmp          (low_line_cmp),
		.power_fail_sense_in   (power_fail_sense_in),
		.cell_good_cmp         (cell_good_cmp),
		.supply_valid_cmp      (supply_valid_cmp),
		.supply_above_cell_cmp (supply_above_cell_cmp),
		.manual_reset_n        (manual_reset_n),
		.watchdog_kick_in      (watchdog_kick_in),
		.watchdog_float_in     (watchdog_float_in),
		.chip_enable_in_n      (chip_enable_in_n),
		.reset_out_n           (reset_out_n),
		.reset_out             (reset_out),
		.power_fail_flag_n     (power_fail_flag_n),
		.power_flag_valid      (power_flag_valid),
		.low_line_n            (low_line_n),
		.watchdog_fault_n      (watchdog_fault_n),
		.backup_cell_good      (backup_cell_good),
		.battery_selected      (battery_selected),
		.chip_enable_out_n     (chip_enable_out_n),
		.gate_enabled          (gate_enabled)
	);
	sss_cpu_model sss_cpu_model_inst (
		.clock       (clock),
		.reset_n     (reset_n),
		.reset_out_n (reset_out_n),
		.low_line_n  (low_line_n),
		.fault_n     (watchdog_fault_n),
		.kick_en     (kick_en),
		.loop_en     (loop_en),
		.kick_q      (watchdog_kick_in),
		.mr_n        (mr_n)
	);
	initial forever #2.5 clock = !clock;
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task automatic chk(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge clock) begin
		cyc_n++;
		if (cyc_n == 4000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic t_flags;
		for (int i = 0; i < 16; i++) begin
			{power_fail_sense_in, low_line_cmp, cell_good_cmp, supply_valid_cmp} = 4'(i);
			cyc(4);
			chk("pf", power_fail_sense_in, power_fail_flag_n);
			chk("ll", low_line_cmp, low_line_n);
			chk("cg", cell_good_cmp, backup_cell_good);
			chk("vld", supply_valid_cmp, power_flag_valid);
		end
	endtask : t_flags
	task automatic t_supply;
		supply_ok_cmp = 1'h0;
		cyc(4);
		chk("bsel", 1'h0, battery_selected);
		supply_above_cell_cmp = 1'h0;
		cyc(4);
		chk("bsel", 1'h1, battery_selected);
		chk("cg", 1'h0, backup_cell_good);
		chk("rst", 1'h0, reset_out_n);
		chk("gate", 1'h1, gate_enabled);
		cyc(GATE);
		chk("gate", 1'h0, gate_enabled);
		chk("ce", 1'h1, chip_enable_out_n);
		supply_ok_cmp = 1'h1;
		supply_above_cell_cmp = 1'h1;
		cyc(30);
		supply_ok_cmp = 1'h0;
		cyc(1);
		supply_ok_cmp = 1'h1;
		cyc(HOLD);
		chk("rst", 1'h0, reset_out_n);
		cyc(10);
		chk("rst", 1'h1, reset_out_n);
		chk("gate", 1'h1, gate_enabled);
	endtask : t_supply
	task automatic t_manual;
		mr_tb_n = 1'h0;
		cyc(6);
		chk("rst", 1'h0, reset_out_n);
		chk("rsth", 1'h1, reset_out);
		chk("gate", 1'h0, gate_enabled);
		mr_tb_n = 1'h1;
		cyc(HOLD);
		chk("rst", 1'h0, reset_out_n);
		cyc(10);
		chk("rst", 1'h1, reset_out_n);
		chk("ce", 1'h0, chip_enable_out_n);
		chip_enable_in_n = 1'h1;
		cyc(1);
		chk("ce", 1'h1, chip_enable_out_n);
		chip_enable_in_n = 1'h0;
	endtask : t_manual
	task automatic t_dog;
		kick_en = 1'h0;
		cyc(WDOG - 20);
		chk("wdo", 1'h1, watchdog_fault_n);
		cyc(40);
		chk("wdo", 1'h0, watchdog_fault_n);
		cyc(50);
		chk("wdo", 1'h0, watchdog_fault_n);
		kick_en = 1'h1;
		cyc(14);
		chk("wdo", 1'h1, watchdog_fault_n);
		watchdog_float_in = 1'h1;
		kick_en = 1'h0;
		cyc(WDOG + 20);
		chk("wdo", 1'h1, watchdog_fault_n);
		watchdog_float_in = 1'h0;
		loop_en = 1'h1;
		for (int i = 0; i < WDOG + 40 && reset_out_n; i++) cyc(1);
		chk("rst", 1'h0, reset_out_n);
		cyc(3);
		chk("wdo", 1'h1, watchdog_fault_n);
		loop_en = 1'h0;
		kick_en = 1'h1;
		cyc(HOLD + 10);
		chk("rst", 1'h1, reset_out_n);
	endtask : t_dog
	initial begin
		cyc(8);
		chk("rst", 1'h0, reset_out_n);
		chk("gate", 1'h0, gate_enabled);
		reset_n = 1'h1;
		cyc(HOLD + 10);
		chk("rst", 1'h1, reset_out_n);
		t_flags();
		t_supply();
		t_manual();
		t_dog();
		complete_run();
	end
endmodule : tb_top
bind sss_supervisor sss_chk #(.HOLD(HOLD_CYCLES), .WDOG(WDOG_CYCLES), .GATE(GATE_CYCLES))
	sss_chk_inst (.clock, .reset_n, .supply_ok_cmp, .manual_reset_n, .watchdog_kick_in,
	.watchdog_float_in, .chip_enable_in_n, .reset_out_n, .reset_out, .watchdog_fault_n,
	.chip_enable_out_n, .gate_enabled);
`default_nettype wire
